/* rtl/pxalu_top.v */
// Pixel processor datapath: ALU with flags, barrel shifter, data RAM pointers
// What this block does
// - 16-bit ALU, splittable into two byte lanes
// - Operands from latch or bus; result registered
// - Carry, sign, overflow, zero from result
// - Logical ops clear carry and overflow
// - Ten opcodes keep previous flags
// - Flag register readable; bits 1-4 writable only under ops that keep flags
// - Bit 0 zero; bits 5-7 live, read-only
// - Add with carry, subtract with borrow
// - Dual byte add with offset, saturated
// - Dual add symmetric in operands
// - Dual subtract A-B+128, saturated per byte
// - Interrupt opcode raises microcode interrupt condition
// - Marker opcode drives performance pin
// - Barrel shift: arithmetic right, zero-fill left
// - Shift amount write starts shift
// - Shifts leave flags alone
// - 512x16 RAM via four pointers
// - Optional pointer post increment or decrement
// - 9-bit pointers, upper bits read zero
// - One RAM access per cycle
// - Both buses transfer in same cycle
//
// The Wishbone slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "pxalu_defs.vh"
module pxalu_top (
  input wire ref_clk, // 200 MHz core clock
  input wire rstn, // Asynchronous reset, active low
  input wire [4:0] arith_operation_field, // Decoded ALU operation
  input wire [1:0] src_a_sel, // Operand A source
  input wire [1:0] src_b_sel, // Operand B source
  input wire latch_a_load, // Load operand A latch from A bus
  input wire latch_b_load, // Load operand B latch from B bus
  input wire [15:0] a_bus, // A bus value this cycle
  input wire [15:0] b_bus, // B bus value this cycle
  input wire cc_wr, // Write flag register from A bus
  input wire loop_cnt_zero, // Loop counter zero status
  input wire [15:0] r0_value, // Register r0 contents
  input wire [1:0] shift_kind, // Shift kind written this cycle
  input wire ptr_wr, // Write a pointer from A bus
  input wire [1:0] ptr_wr_sel, // Pointer to write
  input wire [1:0] ptr_rd_sel, // Pointer shown on ptr_rdata
  input wire mem_en, // Data RAM access this cycle
  input wire mem_we, // Data RAM write
  input wire mem_wsrc_b, // Write data from B bus, else A bus
  input wire [1:0] mem_ptr_sel, // Pointer used by access
  input wire [1:0] mem_post_mod, // 0 none, 1 increment, 2 decrement
  output reg [15:0] alu_result_reg, // ALU output register
  output wire [15:0] cond_flag_reg, // Flag register read view
  output wire [15:0] shift_result, // Shifter output register
  output wire [15:0] ptr_rdata, // Selected pointer, zero-extended
  output wire [15:0] mem_rdata, // Data RAM read word
  output reg microcode_irq_condition, // Pulse on interrupt opcode
  output reg perf_marker_n, // Performance marker pin, active low
  input wire [3:0] wb_adr_i, // Wishbone address
  input wire [31:0] wb_dat_i, // Wishbone write data
  output reg [31:0] wb_dat_o, // Wishbone read data
  input wire wb_we_i, // Wishbone write enable
  input wire [3:0] wb_sel_i, // Wishbone byte selects
  input wire wb_cyc_i, // Wishbone cycle
  input wire wb_stb_i, // Wishbone strobe
  output reg wb_ack_o // Wishbone acknowledge
);
  reg rst_s1;
  reg rst_n;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // Saturating byte lane: 10-bit sum less offset, or difference plus offset, clamped to 0..255
  function [7:0] sat_lane;
    input [7:0] x;
    input [7:0] y;
    input sub;
    reg [9:0] t;
    begin
      if (sub) begin
        t = {2'b00, x} - {2'b00, y} + {1'b0, `PXALU_OFFSET};
      end else begin
        t = {2'b00, x} + {2'b00, y} - {1'b0, `PXALU_OFFSET};
      end
      if (t[9]) begin
        sat_lane = 8'h00;
      end else if (t[8]) begin
        sat_lane = 8'hff;
      end else begin
        sat_lane = t[7:0];
      end
    end
  endfunction

  // Operand latches and source selection
  reg [15:0] latch_a_reg, latch_b_reg;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_a_reg <= 16'h0000;
      latch_b_reg <= 16'h0000;
    end else begin
      if (latch_a_load) begin
        latch_a_reg <= a_bus;
      end
      if (latch_b_load) begin
        latch_b_reg <= b_bus;
      end
    end
  end
  reg [15:0] opa, opb;
  always @* begin
    case (src_a_sel)
      `PXALU_SRC_ABUS: opa = a_bus;
      `PXALU_SRC_BBUS: opa = b_bus;
      default: opa = latch_a_reg;
    endcase
    case (src_b_sel)
      `PXALU_SRC_ABUS: opb = a_bus;
      `PXALU_SRC_BBUS: opb = b_bus;
      default: opb = latch_b_reg;
    endcase
  end

  // Flag state
  reg carry_reg;
  reg ovf_reg;
  reg sign_reg;
  reg zero_reg;
  // Adder: x + y + cin, with carry into top bit kept for overflow
  reg [15:0] ax, ay;
  reg acin;
  reg use_add;
  reg logic_op;
  reg keep_flags;
  reg dual_op;
  reg [15:0] lres;
  always @* begin
    ax = opa;
    ay = opb;
    acin = 1'b0;
    use_add = 1'b1;
    logic_op = 1'b0;
    keep_flags = 1'b0;
    dual_op = 1'b0;
    lres = 16'h0000;
    case (arith_operation_field)
      `PXALU_OP_NOP: begin keep_flags = 1'b1; use_add = 1'b0; lres = alu_result_reg; end
      `PXALU_OP_PASS_A: begin use_add = 1'b0; logic_op = 1'b1; lres = opa; end
      `PXALU_OP_PASS_B: begin use_add = 1'b0; logic_op = 1'b1; lres = opb; end
      `PXALU_OP_PASS_A_NF: begin use_add = 1'b0; keep_flags = 1'b1; lres = opa; end
      `PXALU_OP_PASS_B_NF: begin use_add = 1'b0; keep_flags = 1'b1; lres = opb; end
      `PXALU_OP_NOT_A: begin use_add = 1'b0; logic_op = 1'b1; lres = ~opa; end
      `PXALU_OP_NOT_B: begin use_add = 1'b0; logic_op = 1'b1; lres = ~opb; end
      `PXALU_OP_AND: begin use_add = 1'b0; logic_op = 1'b1; lres = opa & opb; end
      `PXALU_OP_NA_AND_B: begin use_add = 1'b0; logic_op = 1'b1; lres = ~opa & opb; end
      `PXALU_OP_A_AND_NB: begin use_add = 1'b0; logic_op = 1'b1; lres = opa & ~opb; end
      `PXALU_OP_OR: begin use_add = 1'b0; logic_op = 1'b1; lres = opa | opb; end
      `PXALU_OP_NA_OR_B: begin use_add = 1'b0; logic_op = 1'b1; lres = ~opa | opb; end
      `PXALU_OP_A_OR_NB: begin use_add = 1'b0; logic_op = 1'b1; lres = opa | ~opb; end
      `PXALU_OP_XOR: begin use_add = 1'b0; logic_op = 1'b1; lres = opa ^ opb; end
      `PXALU_OP_ADD: begin
        ax = opa;
        ay = opb;
      end
      `PXALU_OP_ADD1: begin
        ax = opa;
        ay = opb;
        acin = 1'b1;
      end
      `PXALU_OP_SUB: begin
        ax = opa;
        ay = ~opb;
        acin = 1'b1;
      end
      `PXALU_OP_RSUB: begin
        ax = ~opa;
        ay = opb;
        acin = 1'b1;
      end
      `PXALU_OP_NEG_A: begin
        ax = ~opa;
        ay = 16'h0000;
        acin = 1'b1;
      end
      `PXALU_OP_NEG_B: begin
        ax = 16'h0000;
        ay = ~opb;
        acin = 1'b1;
      end
      `PXALU_OP_INC_A: begin
        ax = opa;
        ay = 16'h0000;
        acin = 1'b1;
      end
      `PXALU_OP_INC_B: begin
        ax = 16'h0000;
        ay = opb;
        acin = 1'b1;
      end
      `PXALU_OP_DEC_A: begin
        ax = opa;
        ay = 16'hffff;
      end
      `PXALU_OP_DEC_B: begin
        ax = 16'hffff;
        ay = opb;
      end
      // Borrow is the inverted carry, so carry feeds straight in for both
      `PXALU_OP_ADC: begin
        ax = opa;
        ay = opb;
        acin = carry_reg;
      end
      `PXALU_OP_SBB: begin
        ax = opa;
        ay = ~opb;
        acin = carry_reg;
      end
      `PXALU_OP_RSBB: begin
        ax = ~opa;
        ay = opb;
        acin = carry_reg;
      end
      `PXALU_OP_DADDS: begin use_add = 1'b0; dual_op = 1'b1;
        lres = {sat_lane(opa[15:8], opb[15:8], 1'b0), sat_lane(opa[7:0], opb[7:0], 1'b0)}; end
      `PXALU_OP_DSUBS: begin use_add = 1'b0; dual_op = 1'b1;
        lres = {sat_lane(opa[15:8], opb[15:8], 1'b1), sat_lane(opa[7:0], opb[7:0], 1'b1)}; end
      `PXALU_OP_ZERO: begin use_add = 1'b0; keep_flags = 1'b1; lres = 16'h0000; end
      `PXALU_OP_INT: begin
        use_add = 1'b0;
        keep_flags = 1'b1;
        lres = alu_result_reg;
      end
      `PXALU_OP_PROF: begin
        use_add = 1'b0;
        keep_flags = 1'b1;
        lres = alu_result_reg;
      end
      default: begin use_add = 1'b0; keep_flags = 1'b1; lres = alu_result_reg; end
    endcase
  end
  // The +1 and -1 ops keep flags as well
  wire inc_dec = (arith_operation_field == `PXALU_OP_INC_A) || (arith_operation_field == `PXALU_OP_INC_B) ||
                 (arith_operation_field == `PXALU_OP_DEC_A) || (arith_operation_field == `PXALU_OP_DEC_B);
  wire [15:0] low_sum = {1'b0, ax[14:0]} + {1'b0, ay[14:0]} + {15'h0000, acin};
  wire c_into_top = low_sum[15];
  wire [1:0] top_sum = {1'b0, ax[15]} + {1'b0, ay[15]} + {1'b0, c_into_top};
  wire [15:0] sum = {top_sum[0], low_sum[14:0]};
  wire [15:0] result = use_add ? sum : lres;
  // Logical and dual-lane results never report carry or overflow
  wire clear_cv = logic_op || dual_op;
  wire new_carry = (use_add && !clear_cv) ? top_sum[1] : 1'b0;
  wire new_ovf = (use_add && !clear_cv) ? (top_sum[1] ^ c_into_top) : 1'b0;
  wire flag_update = !(keep_flags || inc_dec);

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alu_result_reg <= 16'h0000;
      {zero_reg, sign_reg, ovf_reg, carry_reg} <= `PXALU_CC_RESET;
      microcode_irq_condition <= 1'b0;
      perf_marker_n <= 1'b1;
    end else begin
      alu_result_reg <= result;
      if (flag_update) begin
        carry_reg <= new_carry;
        ovf_reg <= new_ovf;
        sign_reg <= result[15];
        zero_reg <= (result == 16'h0000);
      end else if (cc_wr) begin
        carry_reg <= a_bus[`PXALU_CC_CARRY];
        ovf_reg <= a_bus[`PXALU_CC_OVF];
        sign_reg <= a_bus[`PXALU_CC_SIGN];
        zero_reg <= a_bus[`PXALU_CC_ZERO];
      end
      microcode_irq_condition <= (arith_operation_field == `PXALU_OP_INT);
      perf_marker_n <= ~(arith_operation_field == `PXALU_OP_PROF);
    end
  end
  // Upper byte reads zero; software must not rely on it
  assign cond_flag_reg = {8'h00, r0_value[15], r0_value[0], loop_cnt_zero,
                          zero_reg, sign_reg, ovf_reg, carry_reg, 1'b0};

  // Barrel shifter runs beside the ALU in the same cycle
  pxalu_shifter u_shift (
    .clk(ref_clk),
    .rst_n(rst_n),
    .kind(shift_kind),
    .amount(a_bus[3:0]),
    .operand(b_bus),
    .result_reg(shift_result)
  );

  // Data RAM pointers
  reg [8:0] ptr_reg [0:3];
  integer i;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < 4; i = i + 1) begin
        ptr_reg[i] <= 9'h000;
      end
    end else begin
      if (mem_en && mem_post_mod == 2'h1) begin
        ptr_reg[mem_ptr_sel] <= ptr_reg[mem_ptr_sel] + 9'h001;
      end else if (mem_en && mem_post_mod == 2'h2) begin
        ptr_reg[mem_ptr_sel] <= ptr_reg[mem_ptr_sel] - 9'h001;
      end
      // A pointer load wins over a post-modify of the same pointer
      if (ptr_wr) begin
        ptr_reg[ptr_wr_sel] <= a_bus[8:0];
      end
    end
  end
  assign ptr_rdata = {7'h00, ptr_reg[ptr_rd_sel]};

  // Single port: one access per cycle by construction
  pxalu_dram u_dram (
    .clk(ref_clk),
    .en(mem_en),
    .we(mem_we),
    .addr(ptr_reg[mem_ptr_sel]),
    .wdata(mem_wsrc_b ? b_bus : a_bus),
    .rdata(mem_rdata)
  );

  // Wishbone debug view is read-only; writes are acknowledged and dropped
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `PXALU_WB_CC: wb_dat_o <= {16'h0000, cond_flag_reg};
          `PXALU_WB_ALU: wb_dat_o <= {16'h0000, alu_result_reg};
          `PXALU_WB_SHIFT: wb_dat_o <= {16'h0000, shift_result};
          `PXALU_WB_STAT: wb_dat_o <= {30'h0, microcode_irq_condition, ~perf_marker_n};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // pxalu_top

/* include/pxalu_defs.vh */
// Constants for the pixel ALU, shifter and data RAM datapath
`ifndef PXALU_DEFS_VH
`define PXALU_DEFS_VH
// Arithmetic operation codes (decoded by the instruction decoder)
`define PXALU_OP_NOP 5'h00
`define PXALU_OP_PASS_A 5'h01
`define PXALU_OP_PASS_B 5'h02
`define PXALU_OP_NOT_A 5'h03
`define PXALU_OP_NOT_B 5'h04
`define PXALU_OP_AND 5'h05
`define PXALU_OP_NA_AND_B 5'h06
`define PXALU_OP_A_AND_NB 5'h07
`define PXALU_OP_OR 5'h08
`define PXALU_OP_XOR 5'h09
`define PXALU_OP_ADD 5'h0a
`define PXALU_OP_ADD1 5'h0b
`define PXALU_OP_SUB 5'h0c
`define PXALU_OP_RSUB 5'h0d
`define PXALU_OP_NEG_A 5'h0e
`define PXALU_OP_NEG_B 5'h0f
`define PXALU_OP_INC_A 5'h10
`define PXALU_OP_INC_B 5'h11
`define PXALU_OP_DEC_A 5'h12
`define PXALU_OP_DEC_B 5'h13
`define PXALU_OP_DADDS 5'h14
`define PXALU_OP_ADC 5'h15
`define PXALU_OP_SBB 5'h16
`define PXALU_OP_RSBB 5'h17
`define PXALU_OP_INT 5'h18
`define PXALU_OP_ZERO 5'h19
`define PXALU_OP_PASS_A_NF 5'h1a
`define PXALU_OP_PASS_B_NF 5'h1b
`define PXALU_OP_NA_OR_B 5'h1c
`define PXALU_OP_A_OR_NB 5'h1d
`define PXALU_OP_DSUBS 5'h1e
`define PXALU_OP_PROF 5'h1f
// Operand source select
`define PXALU_SRC_LATCH 2'h0
`define PXALU_SRC_ABUS 2'h1
`define PXALU_SRC_BBUS 2'h2
// Shift kinds
`define PXALU_SH_NONE 2'h0
`define PXALU_SH_RIGHT 2'h1
`define PXALU_SH_RIGHT_L 2'h2
`define PXALU_SH_LEFT 2'h3
// Flag register bit positions
`define PXALU_CC_CARRY 1
`define PXALU_CC_OVF 2
`define PXALU_CC_SIGN 3
`define PXALU_CC_ZERO 4
`define PXALU_CC_LCZ 5
`define PXALU_CC_R0L 6
`define PXALU_CC_R0M 7
`define PXALU_CC_RESET 4'h0
// Data RAM geometry
`define PXALU_DRAM_AW 9
`define PXALU_DRAM_DEPTH 512
`define PXALU_OFFSET 9'h080
// Wishbone register offsets (byte addresses)
`define PXALU_WB_CC 4'h0
`define PXALU_WB_ALU 4'h4
`define PXALU_WB_SHIFT 4'h8
`define PXALU_WB_STAT 4'hc
`endif

/* rtl/pxalu_shifter.v */
// Single-cycle barrel shifter with output register
`timescale 1ns/1ps
`include "pxalu_defs.vh"
module pxalu_shifter (
  input wire clk, // Core clock
  input wire rst_n, // Synchronised reset
  input wire [1:0] kind, // Shift kind, none when idle
  input wire [3:0] amount, // Shift amount from A bus
  input wire [15:0] operand, // Operand from B bus
  output reg [15:0] result_reg // Shifter output register
);
  reg [15:0] result_next;
  always @* begin
    case (kind)
      `PXALU_SH_RIGHT, `PXALU_SH_RIGHT_L: result_next = $signed(operand) >>> amount;
      `PXALU_SH_LEFT: result_next = operand << amount;
      default: result_next = result_reg;
    endcase
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_reg <= 16'h0000;
    end else begin
      result_reg <= result_next;
    end
  end
endmodule // pxalu_shifter

/* rtl/pxalu_dram.v */
// 512 x 16 data memory with registered read data
`timescale 1ns/1ps
`include "pxalu_defs.vh"
module pxalu_dram (
  input wire clk, // Core clock
  input wire en, // Access this cycle
  input wire we, // Write when set
  input wire [8:0] addr, // Word address
  input wire [15:0] wdata, // Write data
  output reg [15:0] rdata // Registered read data
);
  reg [15:0] mem [0:`PXALU_DRAM_DEPTH-1];
  always @(posedge clk) begin
    if (en) begin
      if (we) begin
        mem[addr] <= wdata;
      end else begin
        rdata <= mem[addr];
      end
    end
  end
endmodule // pxalu_dram

/* verif/pxalu_seq_model.sv */
// Sequencer model that drives the two internal buses
`timescale 1ns/1ps
module pxalu_seq_model (
  input wire cc_wr, // Flag register written this cycle
  input wire [15:0] a_req, // Value microcode puts on the A bus
  input wire [15:0] b_req, // Value microcode puts on the B bus
  output wire [15:0] a_bus, // A bus toward the datapath
  output wire [15:0] b_bus // B bus toward the datapath
);
  // Upper flag byte (bits 15:8) is always written as zero
  assign a_bus = cc_wr ? {8'h00, a_req[7:0]} : a_req;
  assign b_bus = b_req;
endmodule // pxalu_seq_model

/* verif/pxalu_props.sv */
// Port-level assertions for the pixel datapath
`timescale 1ns/1ps
`include "pxalu_defs.vh"
module pxalu_props (
  input wire ref_clk, // Clock
  input wire rstn, // Reset, low
  input wire [4:0] arith_operation_field, // Op
  input wire [1:0] src_a_sel, // A source
  input wire [1:0] src_b_sel, // B source
  input wire [15:0] a_bus, // A bus
  input wire [15:0] b_bus, // B bus
  input wire cc_wr, // Flag write
  input wire loop_cnt_zero, // Loop status
  input wire [15:0] r0_value, // r0
  input wire [1:0] shift_kind, // Shift kind
  input wire [15:0] alu_result_reg, // Result
  input wire [15:0] cond_flag_reg, // Flags
  input wire [15:0] shift_result, // Shift out
  input wire [15:0] ptr_rdata, // Pointer view
  input wire microcode_irq_condition, // Irq
  input wire perf_marker_n, // Marker
  input wire wb_cyc_i, // Cycle
  input wire wb_stb_i, // Strobe
  input wire wb_ack_o // Ack
);
  wire [4:0] op = arith_operation_field;
  wire [15:0] sum_c = a_bus + b_bus;
  wire [15:0] shl_c = b_bus << a_bus[3:0];
  wire [15:0] sra_c = $signed(b_bus) >>> a_bus[3:0];
  wire [3:0] bus_cc = a_bus[4:1];
  wire [4:1] flg = cond_flag_reg[4:1];
  wire int_c = op == `PXALU_OP_INT;
  wire prof_c = op == `PXALU_OP_PROF;
  wire add_c = op == `PXALU_OP_ADD && src_a_sel == `PXALU_SRC_ABUS && src_b_sel == `PXALU_SRC_BBUS;
  wire logic_c = op >= `PXALU_OP_AND && op <= `PXALU_OP_XOR;
  wire keep_c = !cc_wr && (op == `PXALU_OP_NOP || op == `PXALU_OP_INT || op == `PXALU_OP_PROF ||
    op == `PXALU_OP_ZERO || op == `PXALU_OP_PASS_A_NF || op == `PXALU_OP_PASS_B_NF);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ack_once; wb_ack_o ##1 !wb_ack_o; endsequence
  a_ack_once: assert property (s_req |=> s_ack_once) else $error("bus ack not one cycle");
  a_add_sum: assert property (add_c |=> alu_result_reg == $past(sum_c)) else $error("sum wrong");
  a_zero_sign: assert property (add_c |=> flg[4] == (alu_result_reg == 16'h0000) && flg[3] == alu_result_reg[15])
    else $error("zero or sign flag wrong");
  a_logic_cv: assert property (logic_c |=> flg[2:1] == 2'h0) else $error("logic op carry set");
  a_keep_flags: assert property (keep_c |=> $stable(flg)) else $error("flags disturbed");
  a_cc_write: assert property (cc_wr && op == `PXALU_OP_NOP |=> flg == $past(bus_cc))
    else $error("flag write lost");
  a_live_bits: assert property (cond_flag_reg[7:5] == {r0_value[15], r0_value[0], loop_cnt_zero} &&
    !cond_flag_reg[0]) else $error("live flag bits wrong");
  a_irq_pulse: assert property (microcode_irq_condition == $past(int_c)) else $error("irq pulse wrong");
  a_marker_low: assert property (perf_marker_n == !$past(prof_c)) else $error("marker wrong");
  a_shift_left: assert property (shift_kind == `PXALU_SH_LEFT |=> shift_result == $past(shl_c))
    else $error("left shift wrong");
  a_shift_right: assert property (shift_kind == `PXALU_SH_RIGHT || shift_kind == `PXALU_SH_RIGHT_L |=>
    shift_result == $past(sra_c)) else $error("right shift wrong");
  a_ptr_upper: assert property (ptr_rdata[15:9] == 7'h00) else $error("pointer upper bits set");
endmodule // pxalu_props
bind pxalu_top pxalu_props pxalu_props_i (.ref_clk(ref_clk), .rstn(rstn),
  .arith_operation_field(arith_operation_field), .src_a_sel(src_a_sel), .src_b_sel(src_b_sel),
  .a_bus(a_bus), .b_bus(b_bus), .cc_wr(cc_wr), .loop_cnt_zero(loop_cnt_zero), .r0_value(r0_value),
  .shift_kind(shift_kind), .alu_result_reg(alu_result_reg), .cond_flag_reg(cond_flag_reg),
  .shift_result(shift_result), .ptr_rdata(ptr_rdata), .microcode_irq_condition(microcode_irq_condition),
  .perf_marker_n(perf_marker_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

/* verif/testbench.sv */
// Self-checking bench for the pixel datapath
`timescale 1ns/1ps
`include "pxalu_defs.vh"
module testbench;
  logic ref_clk = 0, rstn = 0, lal = 0, lbl = 0, ccw = 0, lcz = 0, pw = 0, me = 0, mw = 0, mwb = 0;
  logic [4:0] op = 0;
  logic [1:0] sa = 1, sb = 2, sk = 0, pws = 0, prs = 0, mps = 0, mpm = 0;
  logic [15:0] ar = 0, br = 0, r0 = 0, a_bus, b_bus, alu_q, cc_q, sh_q, pr_q, mr_q, a, b, d, she;
  logic irq_q, pm_q, ack, cyc_i = 0, stb = 0, we = 0;
  logic [3:0] adr = 0;
  logic [31:0] wdat = 0, rdat;
  typedef struct {int due; int sel; logic [31:0] v;} pxalu_note_t;
  pxalu_note_t q[$];
  string nm[7] = '{"alu", "flags", "shift", "mem", "ptr", "wb", "pulse"};
  int cyc = 0, errors = 0, check_count = 0;
  logic [15:0] mres = 0;
  logic [4:1] mf = 0;
  bit fk = 1;
  pxalu_seq_model pxalu_seq_model_i (.cc_wr(ccw), .a_req(ar), .b_req(br), .a_bus(a_bus), .b_bus(b_bus));
  pxalu_top pxalu_top_i (.ref_clk(ref_clk), .rstn(rstn), .arith_operation_field(op), .src_a_sel(sa),
    .src_b_sel(sb), .latch_a_load(lal), .latch_b_load(lbl), .a_bus(a_bus), .b_bus(b_bus), .cc_wr(ccw),
    .loop_cnt_zero(lcz), .r0_value(r0), .shift_kind(sk), .ptr_wr(pw), .ptr_wr_sel(pws), .ptr_rd_sel(prs),
    .mem_en(me), .mem_we(mw), .mem_wsrc_b(mwb), .mem_ptr_sel(mps), .mem_post_mod(mpm), .alu_result_reg(alu_q),
    .cond_flag_reg(cc_q), .shift_result(sh_q), .ptr_rdata(pr_q), .mem_rdata(mr_q), .microcode_irq_condition(irq_q),
    .perf_marker_n(pm_q), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'hf),
    .wb_cyc_i(cyc_i), .wb_stb_i(stb), .wb_ack_o(ack));
  initial forever #2.5 ref_clk = ~ref_clk;
  task automatic test_done;
    if (errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(string n, logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [31:0] seen(int s);
    case (s)
      0: return {16'h0, alu_q};
      1: return {24'h0, cc_q[7:0]};
      2: return {16'h0, sh_q};
      3: return {16'h0, mr_q};
      4: return {16'h0, pr_q};
      6: return {30'h0, irq_q, pm_q};
      default: return rdat;
    endcase
  endfunction
  // Flag bits 7:5 follow live inputs, so they are filled in when compared
  always @(negedge ref_clk)
    while (q.size() > 0 && q[0].due <= cyc) begin
      cmp(nm[q[0].sel], seen(q[0].sel), q[0].sel == 1 ? {24'h0, r0[15], r0[0], lcz, q[0].v[4:0]} : q[0].v);
      void'(q.pop_front());
    end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc > 6000) begin
      errors++;
      test_done();
    end
  end
  task automatic note(int dl, int s, logic [31:0] v);
    q.push_back('{cyc + dl, s, v});
  endtask
  task automatic step(logic [4:0] o, logic [15:0] x, logic [15:0] y);
    @(posedge ref_clk);
    op <= o; ar <= x; br <= y; r0 <= 16'($urandom); lcz <= 1'($urandom);
  endtask
  task automatic wb(logic w, logic [3:0] ad, logic [31:0] e);
    @(posedge ref_clk);
    cyc_i <= 1; stb <= 1; we <= w; adr <= ad; wdat <= $urandom;
    do @(posedge ref_clk); while (ack !== 1'b1);
    if (!w) note(1, 5, e);
    cyc_i <= 0; stb <= 0; we <= 0;
  endtask
  task automatic ref_op(logic [4:0] o, logic [15:0] a, logic [15:0] b);
    logic [16:0] s;
    logic [15:0] x, y;
    logic c;
    int k, v;
    x = a; y = b; c = 0; k = 2;
    case (o)
      `PXALU_OP_NOP, `PXALU_OP_INT, `PXALU_OP_PROF: begin k = 0; x = mres; y = 0; end
      `PXALU_OP_PASS_A_NF: begin k = 0; y = 0; end
      `PXALU_OP_PASS_B_NF: begin k = 0; x = 0; end
      `PXALU_OP_ZERO: begin k = 0; x = 0; y = 0; end
      `PXALU_OP_PASS_A: begin k = 1; y = 0; end
      `PXALU_OP_PASS_B: begin k = 1; x = 0; end
      `PXALU_OP_NOT_A: begin k = 1; x = ~a; y = 0; end
      `PXALU_OP_NOT_B: begin k = 1; x = ~b; y = 0; end
      `PXALU_OP_AND: begin k = 1; x = a & b; y = 0; end
      `PXALU_OP_NA_AND_B: begin k = 1; x = ~a & b; y = 0; end
      `PXALU_OP_A_AND_NB: begin k = 1; x = a & ~b; y = 0; end
      `PXALU_OP_OR: begin k = 1; x = a | b; y = 0; end
      `PXALU_OP_XOR: begin k = 1; x = a ^ b; y = 0; end
      `PXALU_OP_NA_OR_B: begin k = 1; x = ~a | b; y = 0; end
      `PXALU_OP_A_OR_NB: begin k = 1; x = a | ~b; y = 0; end
      `PXALU_OP_ADD1: c = 1;
      `PXALU_OP_SUB: begin y = ~b; c = 1; end
      `PXALU_OP_RSUB: begin x = ~a; c = 1; end
      `PXALU_OP_NEG_A: begin x = ~a; y = 0; c = 1; end
      `PXALU_OP_NEG_B: begin x = 0; y = ~b; c = 1; end
      `PXALU_OP_INC_A: begin k = 3; y = 0; c = 1; end
      `PXALU_OP_INC_B: begin k = 3; x = 0; c = 1; end
      `PXALU_OP_DEC_A: begin k = 3; y = 16'hffff; end
      `PXALU_OP_DEC_B: begin k = 3; x = 16'hffff; end
      `PXALU_OP_ADC: c = mf[1];
      `PXALU_OP_SBB: begin y = ~b; c = mf[1]; end
      `PXALU_OP_RSBB: begin x = ~a; c = mf[1]; end
      `PXALU_OP_DADDS, `PXALU_OP_DSUBS: begin
        k = 1; y = 0;
        for (int l = 0; l < 16; l += 8) begin
          v = o == `PXALU_OP_DADDS ? a[l+:8] + b[l+:8] - 128 : a[l+:8] - b[l+:8] + 128;
          x[l+:8] = v < 0 ? 8'h00 : v > 255 ? 8'hff : v[7:0];
        end
      end
      default: ;
    endcase
    s = x + y + c;
    mres = s[15:0];
    if (k == 3) fk = 0;
    else if (k > 0) begin
      fk = 1;
      mf = {s[15:0] == 16'h0, s[15], k == 2 && (s[16] ^ x[15] ^ y[15] ^ s[15]), k == 2 && s[16]};
    end
  endtask
  initial begin
    void'($urandom(86));
    repeat (12) @(posedge ref_clk);
    rstn <= 1;
    repeat (3) @(posedge ref_clk);
    note(1, 1, 0);
    for (int p = 0; p < 4; p++)
      for (int k = 0; k < 32; k++) begin
        a = p == 0 ? 16'hffff : p == 1 ? 16'h8000 : 16'($urandom);
        b = p == 0 ? 16'h0001 : p == 1 ? 16'h8000 : 16'($urandom);
        step(k[4:0], a, b);
        ref_op(k[4:0], a, b);
        note(2, 0, mres);
        if (fk) note(2, 1, {mf, 1'b0});
        note(2, 6, {30'h0, k[4:0] == `PXALU_OP_INT, k[4:0] != `PXALU_OP_PROF});
      end
    a = 16'($urandom); b = 16'($urandom);
    step(`PXALU_OP_NOP, b, a); lal <= 1; lbl <= 1;
    step(`PXALU_OP_DADDS, 0, 0); lal <= 0; lbl <= 0; sa <= 0; sb <= 0;
    ref_op(`PXALU_OP_DADDS, a, b);
    note(2, 0, mres);
    step(`PXALU_OP_NOP, 0, 0); sa <= 1; sb <= 2;
    for (int k = 0; k < 48; k++) begin
      a = 16'($urandom); b = 16'($urandom);
      step(`PXALU_OP_NOP, a, b); sk <= 2'(k % 3 + 1);
      if (k % 3 == 2) she = b << a[3:0];
      else she = $signed(b) >>> a[3:0];
      note(2, 2, she);
    end
    step(`PXALU_OP_NOP, 0, 0); sk <= 0;
    note(2, 1, {mf, 1'b0});
    for (int k = 0; k < 8; k++) begin
      a = 16'($urandom); step(`PXALU_OP_NOP, a, 0); ccw <= 1;
      mf = a[4:1];
      note(2, 1, {mf, 1'b0});
    end
    step(`PXALU_OP_NOP, 0, 0); ccw <= 0;
    for (int p = 0; p < 4; p++) begin
      a = 16'(2 + $urandom % 500); b = 16'($urandom); d = 16'($urandom);
      step(`PXALU_OP_NOP, a | 16'hfe00, 0); pw <= 1; pws <= 2'(p); prs <= 2'(p);
      note(2, 4, a);
      step(`PXALU_OP_NOP, b, 0); pw <= 0; me <= 1; mw <= 1; mwb <= 0; mpm <= 1; mps <= 2'(p);
      step(`PXALU_OP_NOP, 0, d); mwb <= 1; mpm <= 2;
      step(`PXALU_OP_NOP, 0, 0); mw <= 0; mpm <= 1;
      note(3, 3, b);
      step(`PXALU_OP_NOP, 0, 0); me <= 0; mpm <= 0;
      step(`PXALU_OP_NOP, 0, 0); me <= 1;
      note(3, 3, d);
      step(`PXALU_OP_NOP, 0, 0); me <= 0;
      note(1, 4, a + 16'h1);
      step(`PXALU_OP_NOP, 0, 0);
    end
    wb(1, `PXALU_WB_CC, 0);
    wb(0, `PXALU_WB_CC, {24'h0, r0[15], r0[0], lcz, mf, 1'b0});
    wb(0, `PXALU_WB_ALU, {16'h0, mres});
    wb(0, `PXALU_WB_SHIFT, {16'h0, she});
    wb(0, 4'h2, 0);
    repeat (4) @(posedge ref_clk);
    test_done();
  end
endmodule // testbench
